// *** hdl/sleep_wakeup_pkg.sv ***
// Contract
// - Sleep clears watchdog, clears powered-down, sets timed-out, oscillator off (code clears watchdog only when it is enabled)
// - Ports hold pre-sleep drive state while asleep
// - Wake on master clear, watchdog, or interrupt
// - Only clockless-capable peripherals may raise wake
// - Clocked peripherals raise no wake while asleep
// - Master clear resets; other wakes continue execution
// - Powered-down set at power-up, cleared by sleep
// - Watchdog wake clears timed-out flag
// - Sleep prefetches instruction at PC plus two
// - Source enable alone gates wake, not global enable
// - Global enable clear: continue in-line after wake
// - Global enable set: next instruction, then vector
// - Interrupt pending before sleep: sleep acts as no-op
// - Interrupt during/after sleep: finish sleep, wake immediately
// - Crystal modes add 1024-period oscillator start-up delay
// - Watchdog resets awake device, wakes sleeping one
package sleep_wakeup_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] WAKE_EN_OFFS = 8'h04;
  localparam logic [ADDR_W-1:0] RESET_CAUSE_OFFS = 8'h08;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFFS = 8'h0c;
  localparam logic [ADDR_W-1:0] INT_MASK_OFFS = 8'h10;
  localparam logic [ADDR_W-1:0] PREFETCH_OFFS = 8'h14;
  // Control fields
  localparam int CTRL_DOG_EN_BIT = 0;
  localparam int CTRL_GLOBAL_EN_BIT = 1;
  localparam int CTRL_OSC_LSB = 2;
  // Reset cause fields
  localparam int RC_ASLEEP_BIT = 0;
  localparam int RC_DOWN_BIT = 3;
  localparam int RC_TIMEOUT_BIT = 4;
  // Interrupt status fields
  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_DOG_RESET = 2;
  localparam int EV_MASTER_CLEAR = 3;
  localparam int EV_SLEEP_NOP = 4;
  localparam int EV_N = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  typedef enum logic [1:0] {
    crystal_osc_mode,
    high_speed_osc_mode,
    low_power_osc_mode,
    external_clock_mode
  } osc_mode_t;
  localparam logic [1:0] OSC_MODE_RESET = 2'h0;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OSC_STARTUP_PERIODS = 1024;
  localparam int OSC_PERIOD_PS = 25000;
  localparam int OSC_STARTUP_CYCLES =
    (OSC_STARTUP_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// *** hdl/sleep_wakeup_controller.sv ***
`timescale 1ns/10ps
`default_nettype none
module sleep_wakeup_controller #(
  parameter int NUM_SRC = 8,
  // Sources able to run without the core clock (default all 8 low bits; bit 0 pin, bit 1 port B)
  parameter logic [31:0] CLOCKLESS_MASK = 32'h000000ff,
  parameter int OSC_STARTUP_CYC = sleep_wakeup_pkg::OSC_STARTUP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [sleep_wakeup_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sleep_wakeup_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic [sleep_wakeup_pkg::PC_W-1:0] pc,
  input wire logic [NUM_SRC-1:0] irq_flags,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timeout,
  output logic osc_driver_on,
  output logic io_hold,
  output logic core_run,
  output logic watchdog_clear,
  output logic [sleep_wakeup_pkg::PC_W-1:0] prefetch_addr,
  output logic resume_pulse,
  output logic vector_take,
  output logic device_reset,
  output logic powered_down_flag,
  output logic timed_out_flag,
  output logic irq
);
  import sleep_wakeup_pkg::*;

  initial begin
    if (NUM_SRC < 1 || NUM_SRC > 32) $error("NUM_SRC must be 1..32");
    if (OSC_STARTUP_CYC < 1) $error("OSC_STARTUP_CYC must be positive");
  end

  localparam int CNT_W = $clog2(OSC_STARTUP_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OSC_STARTUP_CYC - 1);

  typedef enum logic [1:0] {st_awake, st_asleep, st_osc_start, st_resume} state_t;
  state_t state;

  logic dog_en;
  logic global_irq_enable;
  osc_mode_t osc_mode;
  logic [NUM_SRC-1:0] wake_en;
  logic [EV_N-1:0] int_status;
  logic [EV_N-1:0] int_mask;
  logic [EV_N-1:0] events;
  logic [CNT_W-1:0] osc_cnt;

  // ----------------------------------------------------------------
  // Wake condition and pin synchronisers
  // ----------------------------------------------------------------
  // Formed from gates only, so a clockless peripheral can raise it while
  // the oscillator is stopped; only its sampled copy enters the logic.
  logic pending_async;
  assign pending_async = |(irq_flags & wake_en & CLOCKLESS_MASK[NUM_SRC-1:0]);

  logic [2:0] async_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] agreed;
  logic [2:0] agreed_d;
  assign async_in = {pending_async, watchdog_timeout, ~master_clear_pin_n};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else if (clk_en) begin
      sync1 <= async_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level counts only once the second and third stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      agreed <= 3'h0;
      agreed_d <= 3'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        if (sync2[i] == sync3[i]) begin
          agreed[i] <= sync3[i];
        end
      end
      agreed_d <= agreed;
    end
  end

  logic pending;
  logic dog_event;
  logic clear_event;
  assign pending = agreed[2];
  assign dog_event = agreed[1] & ~agreed_d[1] & dog_en;
  assign clear_event = agreed[0] & ~agreed_d[0];

  logic sleep_go;
  logic sleep_nop;
  assign sleep_nop = (state == st_awake) && sleep_instr && pending;
  assign sleep_go = (state == st_awake) && sleep_instr && !pending;

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_awake;
      osc_cnt <= '0;
    end else if (clk_en) begin
      if (clear_event) begin
        state <= st_awake;
        osc_cnt <= '0;
      end else begin
        unique case (state)
          st_awake: begin
            if (sleep_go) begin
              state <= st_asleep;
            end
          end
          // A wake already pending moves on at the next edge, after the
          // sleep effects above have been applied in full
          st_asleep: begin
            if (dog_event || pending) begin
              osc_cnt <= '0;
              if (osc_mode == external_clock_mode) begin
                state <= st_resume;
              end else begin
                state <= st_osc_start;
              end
            end
          end
          st_osc_start: begin
            if (osc_cnt == CNT_LAST) begin
              state <= st_resume;
            end else begin
              osc_cnt <= osc_cnt + 1'b1;
            end
          end
          st_resume: begin
            state <= st_awake;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Core-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_driver_on <= 1'b1;
      io_hold <= 1'b0;
      core_run <= 1'b1;
    end else if (clk_en) begin
      if (clear_event) begin
        osc_driver_on <= 1'b1;
        io_hold <= 1'b0;
        core_run <= 1'b1;
      end else if (sleep_go) begin
        osc_driver_on <= 1'b0;
        io_hold <= 1'b1;
        core_run <= 1'b0;
      end else if (state == st_asleep && (dog_event || pending)) begin
        osc_driver_on <= 1'b1;
      end else if (state == st_resume) begin
        io_hold <= 1'b0;
        core_run <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_clear <= 1'b0;
      prefetch_addr <= '0;
      resume_pulse <= 1'b0;
      vector_take <= 1'b0;
      device_reset <= 1'b0;
    end else if (clk_en) begin
      watchdog_clear <= (sleep_go && dog_en) || watchdog_clear_instr;
      if (sleep_go) begin
        prefetch_addr <= pc + PC_STEP;
      end
      // Next instruction runs on each resume not cut by master clear; the vector follows it only with global enable
      resume_pulse <= (state == st_resume) && !clear_event;
      vector_take <= (state == st_resume) && !clear_event && global_irq_enable;
      device_reset <= clear_event || (state == st_awake && dog_event);
    end
  end

  // Power-up leaves both flags set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered_down_flag <= 1'b1;
      timed_out_flag <= 1'b1;
    end else if (clk_en) begin
      if (sleep_go) begin
        powered_down_flag <= 1'b0;
        timed_out_flag <= 1'b1;
      end else if (dog_event) begin
        timed_out_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign events[EV_SLEEP] = sleep_go;
  assign events[EV_WAKE] = (state == st_resume) && !clear_event;
  assign events[EV_DOG_RESET] = (state == st_awake) && dog_event;
  assign events[EV_MASTER_CLEAR] = clear_event;
  assign events[EV_SLEEP_NOP] = sleep_nop;

  logic rd_fire;
  logic [EV_N-1:0] status_clr;
  assign status_clr = (rd_fire && s_axi_araddr == INT_STATUS_OFFS) ? int_status : '0;

  // A new event in the clearing cycle survives the read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
    end else if (clk_en) begin
      int_status <= (int_status & ~status_clr) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(((int_status & ~status_clr) | events) & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic wr_fire;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == CTRL_OFFS || aw_addr == WAKE_EN_OFFS ||
                        aw_addr == INT_MASK_OFFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte lane 0 strobe alone gates every write, including wake enables above bit 7 when NUM_SRC exceeds 8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dog_en <= 1'b0;
      global_irq_enable <= 1'b0;
      osc_mode <= osc_mode_t'(OSC_MODE_RESET);
      wake_en <= '0;
      int_mask <= '0;
    end else if (clk_en && wr_fire && w_strb[0]) begin
      if (aw_addr == CTRL_OFFS) begin
        dog_en <= w_data[CTRL_DOG_EN_BIT];
        global_irq_enable <= w_data[CTRL_GLOBAL_EN_BIT];
        osc_mode <= osc_mode_t'(w_data[CTRL_OSC_LSB +: 2]);
      end
      if (aw_addr == WAKE_EN_OFFS) begin
        wake_en <= w_data[NUM_SRC-1:0];
      end
      if (aw_addr == INT_MASK_OFFS) begin
        int_mask <= w_data[EV_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFFS: begin
        rd_mux[CTRL_DOG_EN_BIT] = dog_en;
        rd_mux[CTRL_GLOBAL_EN_BIT] = global_irq_enable;
        rd_mux[CTRL_OSC_LSB +: 2] = osc_mode;
      end
      WAKE_EN_OFFS: rd_mux[NUM_SRC-1:0] = wake_en;
      RESET_CAUSE_OFFS: begin
        rd_mux[RC_ASLEEP_BIT] = (state != st_awake);
        rd_mux[RC_DOWN_BIT] = powered_down_flag;
        rd_mux[RC_TIMEOUT_BIT] = timed_out_flag;
      end
      INT_STATUS_OFFS: rd_mux[EV_N-1:0] = int_status;
      INT_MASK_OFFS: rd_mux[EV_N-1:0] = int_mask;
      PREFETCH_OFFS: rd_mux[PC_W-1:0] = prefetch_addr;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/sleep_wakeup_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module sleep_wakeup_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_instr,
  input wire logic [sleep_wakeup_pkg::PC_W-1:0] pc,
  input wire logic osc_driver_on,
  input wire logic io_hold,
  input wire logic core_run,
  input wire logic [sleep_wakeup_pkg::PC_W-1:0] prefetch_addr,
  input wire logic resume_pulse,
  input wire logic vector_take,
  input wire logic device_reset,
  input wire logic powered_down_flag,
  input wire logic timed_out_flag
);
  import sleep_wakeup_pkg::*;
  // ----
  // Checks
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sleep_entry_a: assert property ($rose(io_hold) |-> !osc_driver_on && !core_run
    && !powered_down_flag && timed_out_flag) else $error("sleep entry outputs wrong");
  hold_halt_a: assert property (io_hold |-> !core_run)
    else $error("core runs while ports held");
  prefetch_a: assert property ($rose(io_hold) |-> prefetch_addr == $past(pc) + PC_STEP)
    else $error("prefetch address wrong");
  pd_clear_a: assert property ($fell(powered_down_flag) |-> $past(sleep_instr))
    else $error("powered down flag cleared without sleep");
  vector_pair_a: assert property (vector_take |-> resume_pulse)
    else $error("vector without resume");
  resume_run_a: assert property (resume_pulse |-> core_run && !io_hold ##1 !resume_pulse)
    else $error("resume state wrong");
  reset_wake_a: assert property (device_reset |-> !resume_pulse ##1 core_run && !io_hold)
    else $error("master reset state wrong");
  osc_first_a: assert property ($fell(io_hold) |-> $past(osc_driver_on) || device_reset)
    else $error("ports released before oscillator on");
  cover property ($rose(io_hold));
  cover property (vector_take);
  cover property (device_reset);
endmodule
bind sleep_wakeup_controller sleep_wakeup_asserts sleep_wakeup_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .sleep_instr(sleep_instr), .pc(pc),
  .osc_driver_on(osc_driver_on), .io_hold(io_hold), .core_run(core_run),
  .prefetch_addr(prefetch_addr), .resume_pulse(resume_pulse), .vector_take(vector_take),
  .device_reset(device_reset), .powered_down_flag(powered_down_flag),
  .timed_out_flag(timed_out_flag)
);
`default_nettype wire

// *** testbench/core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic aclk,
  input wire logic do_sleep,
  input wire logic [7:0] flags_req,
  input wire logic dog_req,
  input wire logic clear_req,
  output logic sleep_instr,
  output logic [sleep_wakeup_pkg::PC_W-1:0] pc,
  output logic [7:0] irq_flags,
  output logic watchdog_timeout,
  output logic master_clear_pin_n
);
  import sleep_wakeup_pkg::*;
  // ----
  // Core side
  // ----
  initial begin
    sleep_instr = 1'b0;
    pc = 21'h000100;
    irq_flags = 8'h00;
    watchdog_timeout = 1'b0;
    master_clear_pin_n = 1'b1;
  end
  // Sleep sits at a fixed address; the slot after it is a no-op
  always @(posedge aclk) begin
    sleep_instr <= do_sleep;
    pc <= 21'h000100;
    irq_flags <= flags_req;
    watchdog_timeout <= dog_req;
    master_clear_pin_n <= !clear_req;
  end
endmodule
`default_nettype wire

// *** testbench/sleep_wakeup_controller_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sleep_wakeup_controller_tb_top;
  import sleep_wakeup_pkg::*;
  localparam int STARTUP = 8;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, do_sleep, dog_req, clear_req;
  logic sleep_instr, dog_out, clear_n, osc_driver_on, io_hold, core_run, watchdog_clear;
  logic resume_pulse, vector_take, device_reset, down_flag, timeout_flag, irq;
  logic wclr_seen = 1'b0;
  logic [7:0] awaddr, araddr, flags_req, irq_flags;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [PC_W-1:0] pc, prefetch_addr;
  int n_errors = 0, num_checks = 0, cyc = 0, n, base;
  sleep_wakeup_controller #(.NUM_SRC(8), .OSC_STARTUP_CYC(STARTUP)) sleep_wakeup_controller_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_instr(sleep_instr), .watchdog_clear_instr(1'b0), .pc(pc), .irq_flags(irq_flags),
    .master_clear_pin_n(clear_n), .watchdog_timeout(dog_out), .osc_driver_on(osc_driver_on),
    .io_hold(io_hold), .core_run(core_run), .watchdog_clear(watchdog_clear),
    .prefetch_addr(prefetch_addr), .resume_pulse(resume_pulse), .vector_take(vector_take),
    .device_reset(device_reset), .powered_down_flag(down_flag), .timed_out_flag(timeout_flag),
    .irq(irq)
  );
  core_model core_model_inst (
    .aclk(aclk), .do_sleep(do_sleep), .flags_req(flags_req), .dog_req(dog_req),
    .clear_req(clear_req), .sleep_instr(sleep_instr), .pc(pc), .irq_flags(irq_flags),
    .watchdog_timeout(dog_out), .master_clear_pin_n(clear_n)
  );
  // ----
  // Tasks
  // ----
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
        chk("bresp", 32'(bresp), 32'(er));
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done = 1'b1;
        chk("rresp", 32'(rresp), 32'(er));
        chk("rdata", rdata, ed);
      end
    end
  endtask
  task automatic go_sleep();
    @(posedge aclk);
    do_sleep <= 1'b1;
    @(posedge aclk);
    do_sleep <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // Bounded wait for resume (sel 0) or device reset (sel 1)
  task automatic wait_ev(input logic sel, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (!(sel ? device_reset : resume_pulse) && cnt < 100);
    chk("event", 32'(cnt < 100), 32'd1);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (watchdog_clear) wclr_seen <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, do_sleep, dog_req, clear_req} = '0;
    {awaddr, araddr, flags_req, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk("down", 32'(down_flag), 32'd1);
    axr(RESET_CAUSE_OFFS, 32'h18, RESP_OKAY);
    axr(8'h18, 32'h0, RESP_SLVERR);
    axw(RESET_CAUSE_OFFS, 32'h0, RESP_SLVERR);
    axw(WAKE_EN_OFFS, 32'h01, RESP_OKAY);
    axw(INT_MASK_OFFS, 32'h0f, RESP_OKAY);
    axw(CTRL_OFFS, 32'h0f, RESP_OKAY);
    $display("test registers done");
    flags_req <= 8'h01;
    repeat (6) @(posedge aclk);
    go_sleep();
    chk("run", 32'(core_run), 32'd1);
    chk("down", 32'(down_flag), 32'd1);
    chk("wclr", 32'(wclr_seen), 32'd0);
    chk("irq", 32'(irq), 32'd0);
    axw(INT_MASK_OFFS, 32'h1f, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'd1);
    axr(INT_STATUS_OFFS, 32'h10, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'd0);
    flags_req <= 8'h00;
    repeat (6) @(posedge aclk);
    $display("test pending sleep done");
    for (int m = 3; m >= 0; m--) begin
      axw(CTRL_OFFS, 32'(m * 4 + 2), RESP_OKAY);
      go_sleep();
      chk("hold", 32'(io_hold), 32'd1);
      chk("osc", 32'(osc_driver_on), 32'd0);
      chk("down", 32'(down_flag), 32'd0);
      chk("pf", 32'(prefetch_addr), 32'h102);
      flags_req <= 8'h01;
      wait_ev(1'b0, n);
      chk("vec", 32'(vector_take), 32'd1);
      if (m == 3) base = n;
      chk("lat", 32'(n), 32'(base + (m == 3 ? 0 : STARTUP)));
      flags_req <= 8'h00;
      axr(INT_STATUS_OFFS, 32'h03, RESP_OKAY);
      repeat (6) @(posedge aclk);
    end
    $display("test oscillator modes done");
    axw(CTRL_OFFS, 32'h0d, RESP_OKAY);
    go_sleep();
    chk("wclr", 32'(wclr_seen), 32'd1);
    dog_req <= 1'b1;
    wait_ev(1'b0, n);
    chk("vec", 32'(vector_take), 32'd0);
    dog_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("timeout", 32'(timeout_flag), 32'd0);
    axr(RESET_CAUSE_OFFS, 32'h00, RESP_OKAY);
    repeat (6) @(posedge aclk);
    dog_req <= 1'b1;
    wait_ev(1'b1, n);
    dog_req <= 1'b0;
    $display("test watchdog done");
    repeat (6) @(posedge aclk);
    go_sleep();
    clear_req <= 1'b1;
    wait_ev(1'b1, n);
    clear_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("run", 32'(core_run), 32'd1);
    chk("hold", 32'(io_hold), 32'd0);
    $display("test master clear done");
    print_verdict();
  end
endmodule
`default_nettype wire
